/* File: shared/rcsw_pkg.sv */
// constants and types for the reference clock switchover and loop configuration block
package rcsw_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] RCSW_CTRL_OFS = 8'h00;
    localparam logic [7:0] RCSW_STATUS_OFS = 8'h04;
    localparam logic [7:0] RCSW_LOADCAP_OFS = 8'h08;
    localparam logic [7:0] RCSW_LOOP_BASE = 8'h10;
    localparam logic [7:0] RCSW_MULT_BASE = 8'h20;
    // ==========================================================
    // control register fields
    localparam int RCSW_PRIM_BIT = 0;
    localparam int RCSW_MODE_LSB = 1;
    localparam int RCSW_LOAD_LSB = 8;
    localparam int RCSW_DRV_LSB = 16;
    localparam logic RCSW_PRIM_RST = 1'b0;
    localparam logic [1:0] RCSW_MODE_RST = 2'h0;
    localparam logic [4:0] RCSW_LOAD_RST = 5'h00;
    localparam logic [7:0] RCSW_DRV_RST = 8'h11;
    // ==========================================================
    // loop register fields and limits
    localparam int RCSW_DIV_LSB = 0;
    localparam int RCSW_INT_LSB = 8;
    localparam int RCSW_FRAC_LSB = 24;
    localparam logic [6:0] RCSW_DIV_RST = 7'h00;
    localparam logic [11:0] RCSW_INT_RST = 12'h000;
    localparam logic [3:0] RCSW_FRAC_RST = 4'h0;
    localparam logic [6:0] RCSW_DIV_MIN = 7'h01;
    localparam logic [6:0] RCSW_DIV_MIN_L3 = 7'h03;
    localparam logic [13:0] RCSW_MULT_MIN_L0 = 14'h000a;
    localparam logic [13:0] RCSW_MULT_MAX_L0 = 14'h200e;
    localparam logic [13:0] RCSW_MULT_MIN = 14'h0001;
    localparam logic [13:0] RCSW_MULT_MIN_L3 = 14'h000c;
    localparam logic [13:0] RCSW_MULT_MAX = 14'h0fff;
    // ==========================================================
    // load capacitance in eighths of a picofarad, and loss detection
    localparam logic [5:0] RCSW_CAP_BASE = 6'h1c;
    localparam logic [1:0] RCSW_LOSS_EDGES = 2'h2;
    // ==========================================================
    // switch state machine
    typedef enum logic [1:0] {
        RCSW_ST_RUN = 2'b01,
        RCSW_ST_GAP = 2'b10
    } rcsw_state_e;
endpackage

/* File: verif/rcsw_ref_src.sv */
// behavioural model of the two external reference clock sources
`timescale 1ns/1ps
`default_nettype none
module rcsw_ref_src #(
    parameter realtime HALF_A = 530.0,
    parameter realtime HALF_B = 770.0
) (
    input wire logic i_run_a,
    input wire logic i_run_b,
    output logic o_ref_a,
    output logic o_ref_b
);
    // ==========================================
    // oscillators
    // external clocks only, no crystal fitted
    logic a_reg = 1'b0;
    logic b_reg = 1'b0;
    // a stopped source holds its last level
    always #(HALF_A) if (i_run_a) a_reg = ~a_reg;
    // second source never faster than the first
    always #(HALF_B) if (i_run_b) b_reg = ~b_reg;
    assign o_ref_a = a_reg;
    assign o_ref_b = b_reg;
endmodule
`default_nettype wire

/* File: verif/rcsw_tb_top.sv */
// self-checking bench for the reference switchover and loop configuration block
`timescale 1ns/1ps
`default_nettype none
module rcsw_tb_top;
    import rcsw_pkg::*;
    localparam realtime HX = 530.0;
    localparam realtime HC = 770.0;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sel_pin = 1'b0;
    logic run_x = 1'b1;
    logic run_c = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, ref_a, ref_b, ref_clk, sec;
    logic [3:0] pd;
    logic [5:0] cap;
    logic [7:0] drv;
    // {prim, mode, pin, expected secondary, expected source is second input}
    logic [5:0] swtab [7] = '{6'b000000, 6'b000111, 6'b001111, 6'b100001,
                              6'b101110, 6'b010100, 6'b011100};
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    always #50 i_clk = ~i_clk;
    rcsw_ref_src #(.HALF_A(HX), .HALF_B(HC)) SRC (.i_run_a(run_x),
        .i_run_b(run_c), .o_ref_a(ref_a), .o_ref_b(ref_b));
    rcsw_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_crystal_or_reference_input(ref_a),
        .i_second_clock_input(ref_b), .i_input_clock_select_pin(sel_pin),
        .o_ref_clk(ref_clk), .o_secondary_selected(sec), .o_loop_power_down(pd),
        .o_load_cap_eighths(cap), .o_crystal_drive_strength(drv));
    // ==========================================
    // reporting
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ==========================================
    // apb master
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) begin
            @(posedge i_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eerr);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
        chk(e, eerr);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] x;
        logic e;
        apb(1'b0, a, 32'h0, x, e);
        chk(x, exp);
        chk(e, eerr);
    endtask
    // ==========================================
    // expectations and measurement
    function automatic logic [13:0] mult_of(input int k, input logic [11:0] n,
                                            input logic [3:0] f);
        if (k != 0) return {2'b00, n};
        return (f != 4'h0) ? {1'b0, n, 1'b0} + 14'(f) + 14'h1 : {1'b0, n, 1'b0};
    endfunction
    function automatic logic legal_of(input int k, input logic [6:0] d,
                                      input logic [11:0] n, input logic [3:0] f);
        logic [13:0] m;
        m = mult_of(k, n, f);
        if (k == 0) return d >= RCSW_DIV_MIN && m >= RCSW_MULT_MIN_L0 &&
            m <= RCSW_MULT_MAX_L0 && f < n;
        if (k == 3) return d >= RCSW_DIV_MIN_L3 && m >= RCSW_MULT_MIN_L3 && m <= RCSW_MULT_MAX;
        return d >= RCSW_DIV_MIN && m >= RCSW_MULT_MIN && m <= RCSW_MULT_MAX;
    endfunction
    function automatic logic near(input int r, input realtime h);
        int e;
        e = int'(20000.0 / (2.0 * h));
        return (r - e <= 2) && (e - r <= 2);
    endfunction
    // rising edges over 200 cycles after skip, and shortest complete level run
    task automatic measure(input int skip, output int rises, output int minrun);
        int run;
        logic last;
        rises = 0;
        minrun = 999;
        run = -9999;
        last = ref_clk;
        for (int i = 0; i < skip + 200; i++) begin
            @(posedge i_clk);
            if (ref_clk !== last) begin
                if (run > 0 && run < minrun) minrun = run;
                run = 1;
                if (ref_clk === 1'b1 && i >= skip) rises++;
                last = ref_clk;
            end else run++;
        end
    endtask
    task automatic wait_sec(input logic v, output int n);
        n = 0;
        while (sec !== v && n < 100) begin
            @(posedge i_clk);
            n++;
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        int r, m;
        logic [31:0] d, st;
        logic e;
        logic [6:0] dv;
        logic [11:0] n;
        logic [3:0] f;
        logic [4:0] lc;
        logic [5:0] sw;
        r = $urandom(32'h0cedc233);
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk(cap, 32'h1c);
        chk(drv, 32'h11);
        chk(pd, 32'h0);
        chk(sec, 32'h0);
        rdc(RCSW_CTRL_OFS, 32'h00110000, 1'b0);
        rdc(RCSW_LOOP_BASE, 32'h0, 1'b0);
        rdc(8'h30, 32'h0, 1'b1);
        wr(8'h0c, 32'hffffffff, 1'b1);
        wr(RCSW_LOADCAP_OFS, 32'h3f, 1'b0);
        rdc(RCSW_LOADCAP_OFS, 32'h1c, 1'b0);
        for (int i = 0; i < 5; i++) begin
            lc = (i == 0) ? 5'h1f : 5'($urandom);
            wr(RCSW_CTRL_OFS, 32'h00110000 | (32'(lc) << 8), 1'b0);
            chk(cap, 32'h1c + 32'(lc));
            rdc(RCSW_LOADCAP_OFS, 32'h1c + 32'(lc), 1'b0);
        end
        wr(RCSW_CTRL_OFS, 32'h00110000, 1'b0);
        for (int k = 0; k < 4; k++) begin
            for (int t = 0; t < 6; t++) begin
                dv = (k == 3) ? 7'(3 + $urandom % 125) : 7'($urandom);
                n = 12'($urandom);
                f = (k == 0) ? 4'($urandom) : 4'h0;
                if (t < 2) dv = (t == 1) ? 7'h7f : (k == 3) ? 7'h03 : 7'h01;
                if (t == 0) n = (k == 0) ? 12'd5 : (k == 3) ? 12'd12 : 12'd1;
                if (t == 1) n = 12'hfff;
                if (t < 3) f = (k == 0 && t == 1) ? 4'hf : 4'h0;
                if (t == 2) n = (k == 0) ? 12'd4 : (k == 3) ? 12'd11 : 12'd0;
                if (t == 2 && k != 3) dv = 7'h00;
                d = {4'h0, f, 4'h0, n, 1'b0, dv};
                wr(RCSW_LOOP_BASE + 8'(4 * k), d, 1'b0);
                rdc(RCSW_LOOP_BASE + 8'(4 * k), d, 1'b0);
                rdc(RCSW_MULT_BASE + 8'(4 * k), 32'(mult_of(k, n, f)), 1'b0);
                apb(1'b0, RCSW_STATUS_OFS, 32'h0, st, e);
                chk(st[4 + k], dv == 7'h00 && k != 3);
                chk(pd[k], dv == 7'h00 && k != 3);
                if (dv != 7'h00 || k == 3) chk(st[8 + k], legal_of(k, dv, n, f));
            end
        end
        for (int i = 0; i < 7; i++) begin
            sw = swtab[i];
            wr(RCSW_CTRL_OFS, 32'h00110000 | 32'({sw[4:3], sw[5]}), 1'b0);
            sel_pin <= sw[2];
            measure(40, r, m);
            chk(sec, sw[1]);
            chk(near(r, sw[0] ? HC : HX), 32'h1);
            chk(m >= 4, 32'h1);
        end
        wr(RCSW_CTRL_OFS, 32'h00110004, 1'b0);
        sel_pin <= 1'b0;
        repeat (20) @(posedge i_clk);
        run_x <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk(sec, 32'h0);
        wait_sec(1'b1, r);
        chk(r < 80, 32'h1);
        apb(1'b0, RCSW_STATUS_OFS, 32'h0, st, e);
        chk(st[2:0], 32'h7);
        measure(10, r, m);
        chk(near(r, HC), 32'h1);
        run_x <= 1'b1;
        wait_sec(1'b0, r);
        chk(r < 60, 32'h1);
        measure(10, r, m);
        chk(near(r, HX), 32'h1);
        chk(m >= 4, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire

/* File: verilog/rcsw_loop_calc.sv */
// multiplier, legality and power-down decode for one synthesis loop
`timescale 1ns/1ps
`default_nettype none
module rcsw_loop_calc #(
    parameter bit IS_FRAC = 1'b0,
    parameter bit HAS_PD = 1'b1,
    parameter logic [6:0] DIV_MIN = 7'h01,
    parameter logic [13:0] MULT_MIN = 14'h0001,
    parameter logic [13:0] MULT_MAX = 14'h0fff
) (
    input wire logic [6:0] i_div,
    input wire logic [11:0] i_int,
    input wire logic [3:0] i_frac,
    output logic [13:0] o_mult,
    output logic o_power_down,
    output logic o_cfg_ok
);
    logic [13:0] twice;
    logic frac_ok;

    always_comb begin
        twice = {1'b0, i_int, 1'b0};
        frac_ok = 1'b1;
        if (IS_FRAC) begin
            // 2n + a + 1 with a fraction, 2n without
            o_mult = (i_frac != 4'h0) ? twice + {10'h000, i_frac} + 14'h0001 : twice;
            frac_ok = (i_frac == 4'h0) || ({8'h00, i_frac} < i_int);
        end else begin
            o_mult = {2'h0, i_int};
        end
        o_power_down = HAS_PD && (i_div == 7'h00);
        o_cfg_ok = frac_ok && (i_div >= DIV_MIN) && (o_mult >= MULT_MIN) && (o_mult <= MULT_MAX);
    end
endmodule
`default_nettype wire

/* File: verilog/rcsw_sync_edge.sv */
// two-stage synchroniser with edge detection for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module rcsw_sync_edge (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_edge
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~last_reg;
    assign o_edge = sync_reg ^ last_reg;
endmodule
`default_nettype wire

/* File: verilog/rcsw_top.sv */
// reference clock switchover and loop divider configuration with apb registers
//
// Overview of operation
// - loops 0-2 divider 1-127, zero powers down
// - loop 0 multiplier 2n+a+1, or 2n
// - loops 1-3 multiplier equals n directly
// - source bit picks which input is primary
// - mode upper bit low means manual switchover
// - manual mode follows the select pin
// - manual change makes no output glitch
// - two secondary cycles without primary edge switch
// - revert to primary once it returns
// - switching is asynchronous to both references
// - load cap is 3.5 pF plus code steps
`timescale 1ns/1ps
`default_nettype none
module rcsw_top
    import rcsw_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_crystal_or_reference_input,
    input wire logic i_second_clock_input,
    input wire logic i_input_clock_select_pin,
    output logic o_ref_clk,
    output logic o_secondary_selected,
    output logic [3:0] o_loop_power_down,
    output logic [5:0] o_load_cap_eighths,
    output logic [7:0] o_crystal_drive_strength
);
    // ==========================================================
    // pin synchronisers
    logic crf_lvl, crf_rise, crf_edge;
    logic cin_lvl, cin_rise, cin_edge;
    logic csel_lvl;

    rcsw_sync_edge u_sync_crf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_crystal_or_reference_input),
        .o_level(crf_lvl),
        .o_rise(crf_rise),
        .o_edge(crf_edge)
    );
    rcsw_sync_edge u_sync_cin (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_second_clock_input),
        .o_level(cin_lvl),
        .o_rise(cin_rise),
        .o_edge(cin_edge)
    );
    rcsw_sync_edge u_sync_sel (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_input_clock_select_pin),
        .o_level(csel_lvl),
        .o_rise(),
        .o_edge()
    );

    // ==========================================================
    // configuration registers
    logic prim_reg, prim_next;
    logic [1:0] mode_reg, mode_next;
    logic [4:0] load_reg, load_next;
    logic [7:0] drv_reg, drv_next;
    logic [3:0][6:0] div_reg, div_next;
    logic [3:0][11:0] int_reg, int_next;
    logic [3:0] frac_reg, frac_next;
    logic [3:0][13:0] mult;
    logic [3:0] pd_comb, cfg_ok;
    logic [1:0] loss_cnt_reg, loss_cnt_next;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_loop
            rcsw_loop_calc #(
                .IS_FRAC(gi == 0),
                .HAS_PD(gi != 3),
                .DIV_MIN((gi == 3) ? RCSW_DIV_MIN_L3 : RCSW_DIV_MIN),
                .MULT_MIN((gi == 0) ? RCSW_MULT_MIN_L0 :
                          ((gi == 3) ? RCSW_MULT_MIN_L3 : RCSW_MULT_MIN)),
                .MULT_MAX((gi == 0) ? RCSW_MULT_MAX_L0 : RCSW_MULT_MAX)
            ) u_calc (
                .i_div(div_reg[gi]),
                .i_int(int_reg[gi]),
                .i_frac((gi == 0) ? frac_reg : 4'h0),
                .o_mult(mult[gi]),
                .o_power_down(pd_comb[gi]),
                .o_cfg_ok(cfg_ok[gi])
            );
        end
    endgenerate

    // ==========================================================
    // apb slave
    logic access, hit, in_loop, in_mult;
    logic [1:0] idx;
    logic [31:0] rdata;
    logic pready_next, pslverr_next;
    logic [31:0] prdata_next;

    always_comb begin
        access = i_psel && i_penable && !o_pready;
        idx = i_paddr[3:2];
        in_loop = (i_paddr[7:4] == RCSW_LOOP_BASE[7:4]) && (i_paddr[1:0] == 2'h0);
        in_mult = (i_paddr[7:4] == RCSW_MULT_BASE[7:4]) && (i_paddr[1:0] == 2'h0);
        hit = in_loop || in_mult || (i_paddr == RCSW_CTRL_OFS) ||
              (i_paddr == RCSW_STATUS_OFS) || (i_paddr == RCSW_LOADCAP_OFS);
        rdata = 32'h0000_0000;
        if (i_paddr == RCSW_CTRL_OFS) begin
            rdata[RCSW_PRIM_BIT] = prim_reg;
            rdata[RCSW_MODE_LSB +: 2] = mode_reg;
            rdata[RCSW_LOAD_LSB +: 5] = load_reg;
            rdata[RCSW_DRV_LSB +: 8] = drv_reg;
        end else if (i_paddr == RCSW_STATUS_OFS) begin
            rdata[0] = o_secondary_selected;
            rdata[1] = (loss_cnt_reg == RCSW_LOSS_EDGES);
            rdata[2] = mode_reg[1];
            rdata[7:4] = o_loop_power_down;
            rdata[11:8] = cfg_ok;
        end else if (i_paddr == RCSW_LOADCAP_OFS) begin
            rdata[5:0] = o_load_cap_eighths;
        end else if (in_loop) begin
            rdata[RCSW_DIV_LSB +: 7] = div_reg[idx];
            rdata[RCSW_INT_LSB +: 12] = int_reg[idx];
            rdata[RCSW_FRAC_LSB +: 4] = (idx == 2'h0) ? frac_reg : 4'h0;
        end else if (in_mult) begin
            rdata[13:0] = mult[idx];
        end
        pready_next = access;
        pslverr_next = access && !hit;
        prdata_next = access ? rdata : o_prdata;
        prim_next = prim_reg;
        mode_next = mode_reg;
        load_next = load_reg;
        drv_next = drv_reg;
        div_next = div_reg;
        int_next = int_reg;
        frac_next = frac_reg;
        if (access && i_pwrite) begin
            if (i_paddr == RCSW_CTRL_OFS) begin
                prim_next = i_pwdata[RCSW_PRIM_BIT];
                mode_next = i_pwdata[RCSW_MODE_LSB +: 2];
                load_next = i_pwdata[RCSW_LOAD_LSB +: 5];
                drv_next = i_pwdata[RCSW_DRV_LSB +: 8];
            end else if (in_loop) begin
                div_next[idx] = i_pwdata[RCSW_DIV_LSB +: 7];
                int_next[idx] = i_pwdata[RCSW_INT_LSB +: 12];
                if (idx == 2'h0) begin
                    frac_next = i_pwdata[RCSW_FRAC_LSB +: 4];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            prim_reg <= RCSW_PRIM_RST;
            mode_reg <= RCSW_MODE_RST;
            load_reg <= RCSW_LOAD_RST;
            drv_reg <= RCSW_DRV_RST;
            div_reg <= {4{RCSW_DIV_RST}};
            int_reg <= {4{RCSW_INT_RST}};
            frac_reg <= RCSW_FRAC_RST;
        end else begin
            o_pready <= pready_next;
            o_pslverr <= pslverr_next;
            o_prdata <= prdata_next;
            prim_reg <= prim_next;
            mode_reg <= mode_next;
            load_reg <= load_next;
            drv_reg <= drv_next;
            div_reg <= div_next;
            int_reg <= int_next;
            frac_reg <= frac_next;
        end
    end

    // ==========================================================
    // loss detection and glitch-free switch
    logic pri_lvl, sec_lvl, pri_edge, sec_rise;
    logic want, cur_lvl, tgt_lvl;
    rcsw_state_e st_reg, st_next;
    logic sel_next, out_next;
    logic [5:0] cap_next;

    always_comb begin
        // which pin is primary
        pri_lvl = prim_reg ? cin_lvl : crf_lvl;
        sec_lvl = prim_reg ? crf_lvl : cin_lvl;
        pri_edge = prim_reg ? cin_edge : crf_edge;
        sec_rise = prim_reg ? crf_rise : cin_rise;
        loss_cnt_next = loss_cnt_reg;
        if (pri_edge) begin
            loss_cnt_next = 2'h0;
        end else if (sec_rise && loss_cnt_reg != RCSW_LOSS_EDGES) begin
            loss_cnt_next = loss_cnt_reg + 2'h1;
        end
        // manual follows the pin, automatic follows loss and reverts
        if (mode_reg[1]) begin
            want = (loss_cnt_reg == RCSW_LOSS_EDGES);
        end else begin
            want = csel_lvl;
        end
        cur_lvl = o_secondary_selected ? sec_lvl : pri_lvl;
        tgt_lvl = want ? sec_lvl : pri_lvl;
        st_next = st_reg;
        sel_next = o_secondary_selected;
        out_next = 1'b0;
        case (st_reg)
            RCSW_ST_RUN: begin
                out_next = cur_lvl;
                // leave while low, or at once when a lost primary is stuck high
                if (want != o_secondary_selected && (!o_ref_clk || (mode_reg[1] && want))) begin
                    st_next = RCSW_ST_GAP;
                    out_next = 1'b0;
                end
            end
            RCSW_ST_GAP: begin
                if (!tgt_lvl) begin
                    sel_next = want;
                    st_next = RCSW_ST_RUN;
                end
            end
            default: begin
                st_next = RCSW_ST_RUN;
            end
        endcase
        cap_next = RCSW_CAP_BASE + {1'b0, load_reg};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            loss_cnt_reg <= 2'h0;
            st_reg <= RCSW_ST_RUN;
            o_secondary_selected <= 1'b0;
            o_ref_clk <= 1'b0;
            o_loop_power_down <= 4'h0;
            o_load_cap_eighths <= RCSW_CAP_BASE;
            o_crystal_drive_strength <= RCSW_DRV_RST;
        end else begin
            loss_cnt_reg <= loss_cnt_next;
            st_reg <= st_next;
            o_secondary_selected <= sel_next;
            o_ref_clk <= out_next;
            o_loop_power_down <= pd_comb;
            o_load_cap_eighths <= cap_next;
            o_crystal_drive_strength <= drv_reg;
        end
    end

    // ==========================================================
    // assertions
    property p_loop_pd;
        @(posedge i_clk) disable iff (i_rst)
        (!i_rst && div_reg[1] == 7'h00) |=> o_loop_power_down[1];
    endproperty
    a_loop_pd: assert property (p_loop_pd) else $error("loop 1 not powered down");
    property p_l3_div;
        @(posedge i_clk) disable iff (i_rst)
        (div_reg[3] < 7'h03) |-> !cfg_ok[3] && !pd_comb[3];
    endproperty
    a_l3_div: assert property (p_l3_div) else $error("loop 3 low divider accepted");
    property p_mult0;
        @(posedge i_clk) disable iff (i_rst)
        (frac_reg != 4'h0) |-> mult[0] == {1'b0, int_reg[0], 1'b0} + {10'h000, frac_reg} + 14'h1;
    endproperty
    a_mult0: assert property (p_mult0) else $error("loop 0 fractional multiplier wrong");
    property p_mult3;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> mult[3] == {2'h0, int_reg[3]} && (int_reg[3] >= 12'h00c || !cfg_ok[3]);
    endproperty
    a_mult3: assert property (p_mult3) else $error("loop 3 multiplier wrong");
    property p_loss_clear;
        @(posedge i_clk) disable iff (i_rst)
        pri_edge |=> loss_cnt_reg == 2'h0;
    endproperty
    a_loss_clear: assert property (p_loss_clear) else $error("primary edge kept loss count");
    property p_auto_want;
        @(posedge i_clk) disable iff (i_rst)
        mode_reg[1] && $rose(loss_cnt_reg == RCSW_LOSS_EDGES) |-> $past(sec_rise) && !$past(pri_edge);
    endproperty
    a_auto_want: assert property (p_auto_want) else $error("loss seen without cause");
    property p_sel_cause;
        @(posedge i_clk) disable iff (i_rst)
        $changed(o_secondary_selected) |-> $past(st_reg == RCSW_ST_GAP) && $past(want) == o_secondary_selected;
    endproperty
    a_sel_cause: assert property (p_sel_cause) else $error("selection changed without request");
    property p_gap_low;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == RCSW_ST_GAP) |-> !o_ref_clk ##1 (st_reg == RCSW_ST_RUN || !o_ref_clk);
    endproperty
    a_gap_low: assert property (p_gap_low) else $error("output high during switch gap");
    property p_run_follow;
        @(posedge i_clk) disable iff (i_rst)
        (st_reg == RCSW_ST_RUN && !o_secondary_selected && want == 1'b0) |=> o_ref_clk == $past(pri_lvl);
    endproperty
    a_run_follow: assert property (p_run_follow) else $error("primary not passed through");
    property p_cap;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |=> o_load_cap_eighths == RCSW_CAP_BASE + {1'b0, $past(load_reg)};
    endproperty
    a_cap: assert property (p_cap) else $error("load capacitance wrong");
    c_auto_sec: cover property (@(posedge i_clk) disable iff (i_rst)
        mode_reg[1] && $rose(o_secondary_selected));
    c_auto_rev: cover property (@(posedge i_clk) disable iff (i_rst)
        mode_reg[1] && $fell(o_secondary_selected));
    c_manual: cover property (@(posedge i_clk) disable iff (i_rst)
        !mode_reg[1] && $rose(o_secondary_selected));
    c_slverr: cover property (@(posedge i_clk) disable iff (i_rst) o_pready && o_pslverr);
endmodule
`default_nettype wire
